// ### hdl/host_write_capture.sv
// Captures a host write on the rising edge of the write strobe.
`timescale 1ns/1ps
`default_nettype none
`include "output_port_function_mux_cfg.svh"

module host_write_capture (
    input  wire logic                               ref_clk_i,
    input  wire logic                               reset_i,
    input  wire logic                               cs_n_i,
    input  wire logic                               wr_n_i,
    input  wire output_port_function_mux_pkg::byte_t data_i,
    output logic                                    wr_pulse_o,
    output output_port_function_mux_pkg::byte_t     wr_data_o
);

    logic                                wr_active_reg;
    output_port_function_mux_pkg::byte_t hold_reg;

    // Data is held while the strobe is low so the value seen at the rising edge is the one kept.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_active_reg <= 1'b0;
            hold_reg      <= `OPM_DATA_RESET;
        end else begin
            wr_active_reg <= !cs_n_i && !wr_n_i;
            if (!cs_n_i && !wr_n_i) begin
                hold_reg <= data_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pulse_o <= 1'b0;
            wr_data_o  <= `OPM_DATA_RESET;
        end else begin
            wr_pulse_o <= wr_active_reg && wr_n_i;
            if (wr_active_reg && wr_n_i) begin
                wr_data_o <= hold_reg;
            end
        end
    end

    AST_WR_ON_RISE : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!cs_n_i && !wr_n_i) ##1 wr_n_i |=> wr_pulse_o)
        else $error("Write strobe rise was not captured.");

endmodule : host_write_capture
`default_nettype wire

// ### hdl/output_port_function_mux.sv
// Output pin function multiplexer, host data bus drive and interrupt request pin.
//
// Overview of operation
// - Pin one is either a general output or channel B request to send.
// - Pin three is general output, B transmit clock, B receive clock or timer ready.
// - Pin five is general output or open-drain B receiver ready or full.
// - Pin seven is general output or open-drain B transmitter ready.
// - Pin six is general output or open-drain A transmitter ready.
// - Host transfers use the eight-bit data bus, bit 0 least significant.
// - Data bus floats while chip select is high, except acknowledge in Z mode.
// - Interrupt pin pulls low while any unmasked interrupt condition is present.
// - Interrupt stays low until software clears every causing condition.
// - Master reset forces all eight general output pins high.
`timescale 1ns/1ps
`default_nettype none
`include "output_port_function_mux_cfg.svh"

module output_port_function_mux (
    input  wire logic                                    ref_clk_i,
    input  wire logic                                    reset_i,
    // Host bus.
    input  wire logic                                    cs_n_i,
    input  wire logic                                    rd_n_i,
    input  wire logic                                    wr_n_i,
    input  wire logic                                    z_mode_i,
    input  wire logic                                    interrupt_acknowledge_i,
    input  wire output_port_function_mux_pkg::byte_t     data_in_i,
    output output_port_function_mux_pkg::byte_t          data_out_o,
    output logic                                         data_oe_o,
    input  wire output_port_function_mux_pkg::byte_t     read_data_i,
    input  wire output_port_function_mux_pkg::byte_t     vector_i,
    output logic                                         wr_pulse_o,
    output output_port_function_mux_pkg::byte_t          wr_data_o,
    // General output levels and function selects.
    input  wire output_port_function_mux_pkg::byte_t     gpo_drive_low_i,
    input  wire output_port_function_mux_pkg::byte_t     gpo_drive_high_i,
    output output_port_function_mux_pkg::byte_t          gpo_level_o,
    input  wire logic                                    pin1_alt_i,
    input  wire output_port_function_mux_pkg::pin3_func_t pin3_func_i,
    input  wire logic                                    pin5_alt_i,
    input  wire logic                                    pin6_alt_i,
    input  wire logic                                    pin7_alt_i,
    // Alternate function sources.
    input  wire logic                                    chan_b_request_to_send_n_i,
    input  wire logic                                    chan_b_tx_clock_x1_i,
    input  wire logic                                    chan_b_rx_clock_x1_i,
    input  wire logic                                    ct_ready_n_i,
    input  wire logic                                    chan_b_rx_ready_or_full_n_i,
    input  wire logic                                    chan_b_tx_ready_n_i,
    input  wire logic                                    chan_a_tx_ready_n_i,
    // Output pins.
    output output_port_function_mux_pkg::byte_t          out_pin_o,
    output output_port_function_mux_pkg::byte_t          out_pin_oe_o,
    // Interrupt request.
    input  wire output_port_function_mux_pkg::byte_t     int_source_i,
    input  wire output_port_function_mux_pkg::byte_t     int_mask_i,
    output logic                                         interrupt_request_n_o,
    output logic                                         interrupt_request_n_oe_o
);

    output_port_function_mux_pkg::byte_t gpo_level_reg;
    output_port_function_mux_pkg::byte_t gpo_level_next;
    output_port_function_mux_pkg::byte_t pin_level_next;
    output_port_function_mux_pkg::byte_t pin_oe_next;
    logic                                irq_reg;
    logic                                interrupt_acknowledge_drive;

    // Open-drain level: the pin is pulled low when the source is low, and released otherwise.
    function automatic logic [1:0] open_drain(input logic src_n);
        open_drain = {1'b0, !src_n};
    endfunction : open_drain

    // General output: push-pull at the stored level.
    function automatic logic [1:0] push_pull(input logic level);
        push_pull = {level, 1'b1};
    endfunction : push_pull

    host_write_capture u_write_capture (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .cs_n_i    (cs_n_i),
        .wr_n_i    (wr_n_i),
        .data_i    (data_in_i),
        .wr_pulse_o(wr_pulse_o),
        .wr_data_o (wr_data_o)
    );

    // A set and a clear on the same bit in one cycle leave the pin low, the safer idle for active-low lines.
    always_comb begin
        gpo_level_next = (gpo_level_reg | gpo_drive_high_i) & ~gpo_drive_low_i;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gpo_level_reg <= `OPM_GPO_RESET;
        end else begin
            gpo_level_reg <= gpo_level_next;
        end
    end

    assign gpo_level_o = gpo_level_reg;

    always_comb begin
        logic [1:0] p;
        p = 2'b00;
        for (int i = 0; i < 8; i++) begin
            {pin_level_next[i], pin_oe_next[i]} = push_pull(gpo_level_reg[i]);
        end
        if (pin1_alt_i) begin
            p = push_pull(chan_b_request_to_send_n_i);
            {pin_level_next[`OPM_PIN_ONE], pin_oe_next[`OPM_PIN_ONE]} = p;
        end
        case (pin3_func_i)
            output_port_function_mux_pkg::PIN3_TX_CLOCK: p = push_pull(chan_b_tx_clock_x1_i);
            output_port_function_mux_pkg::PIN3_RX_CLOCK: p = push_pull(chan_b_rx_clock_x1_i);
            output_port_function_mux_pkg::PIN3_CT_READY: p = open_drain(ct_ready_n_i);
            default:                                     p = push_pull(gpo_level_reg[`OPM_PIN_THREE]);
        endcase
        {pin_level_next[`OPM_PIN_THREE], pin_oe_next[`OPM_PIN_THREE]} = p;
        if (pin5_alt_i) begin
            p = open_drain(chan_b_rx_ready_or_full_n_i);
            {pin_level_next[`OPM_PIN_FIVE], pin_oe_next[`OPM_PIN_FIVE]} = p;
        end
        if (pin6_alt_i) begin
            p = open_drain(chan_a_tx_ready_n_i);
            {pin_level_next[`OPM_PIN_SIX], pin_oe_next[`OPM_PIN_SIX]} = p;
        end
        if (pin7_alt_i) begin
            p = open_drain(chan_b_tx_ready_n_i);
            {pin_level_next[`OPM_PIN_SEVEN], pin_oe_next[`OPM_PIN_SEVEN]} = p;
        end
    end

    // Pins are registered, so the alternate sources reach the pins one cycle late.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_pin_o    <= `OPM_GPO_RESET;
            out_pin_oe_o <= `OPM_PIN_OE_RESET;
        end else begin
            out_pin_o    <= pin_level_next;
            out_pin_oe_o <= pin_oe_next;
        end
    end

    // The interrupt is a level: it falls away only when no unmasked source remains.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(int_source_i & int_mask_i);
        end
    end

    assign interrupt_request_n_o    = !irq_reg;
    assign interrupt_request_n_oe_o = irq_reg;

    // Enable is combinational so the bus is released in the same cycle chip select rises.
    assign interrupt_acknowledge_drive = z_mode_i && interrupt_acknowledge_i;
    assign data_oe_o  = (!cs_n_i && !rd_n_i) || interrupt_acknowledge_drive;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_out_o <= `OPM_DATA_RESET;
        end else if (interrupt_acknowledge_drive) begin
            data_out_o <= vector_i;
        end else begin
            data_out_o <= read_data_i;
        end
    end

    // The sampled reset in every antecedent except AST_BUS_FLOATS, AST_IRQ_HOLD and AST_RESET_HIGH keeps the release edge out, because the registered
    // pins still show their reset values one cycle after reset falls.
    AST_BUS_FLOATS : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (cs_n_i && !(z_mode_i && interrupt_acknowledge_i)) |-> !data_oe_o)
        else $error("Data bus driven while not selected.");

    AST_BUS_READ : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && !cs_n_i && !rd_n_i && !interrupt_acknowledge_drive) |=> (data_out_o == $past(read_data_i)))
        else $error("Read data not presented on the bus.");

    AST_IRQ_SET : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && |(int_source_i & int_mask_i)) |=> (!interrupt_request_n_o && interrupt_request_n_oe_o))
        else $error("Interrupt not asserted for unmasked source.");

    AST_IRQ_HOLD : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!interrupt_request_n_o && (int_source_i & int_mask_i) == 8'h00) |=> interrupt_request_n_o)
        else $error("Interrupt not released after sources cleared.");

    AST_PIN1_RTS : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin1_alt_i) |=> (out_pin_o[1] == $past(chan_b_request_to_send_n_i)) && out_pin_oe_o[1])
        else $error("Pin one does not follow request to send.");

    AST_PIN3_CT : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin3_func_i == output_port_function_mux_pkg::PIN3_CT_READY) |=>
            (out_pin_oe_o[3] == !$past(ct_ready_n_i)) && !out_pin_o[3])
        else $error("Pin three timer ready not open-drain.");

    AST_PIN3_CLK : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin3_func_i == output_port_function_mux_pkg::PIN3_RX_CLOCK) |=>
            (out_pin_o[3] == $past(chan_b_rx_clock_x1_i)))
        else $error("Pin three does not carry receive clock.");

    AST_PIN5_RX : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin5_alt_i && !chan_b_rx_ready_or_full_n_i) |=> (out_pin_oe_o[5] && !out_pin_o[5]))
        else $error("Pin five not pulled low for receiver ready.");

    AST_PIN7_TX : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin7_alt_i && chan_b_tx_ready_n_i) |=> !out_pin_oe_o[7])
        else $error("Pin seven driven while transmitter not ready.");

    AST_PIN6_TX : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && pin6_alt_i && !chan_a_tx_ready_n_i) |=> (out_pin_oe_o[6] && !out_pin_o[6]))
        else $error("Pin six not pulled low for transmitter ready.");

    AST_RESET_HIGH : assert property (@(posedge ref_clk_i)
        $past(reset_i) |-> (out_pin_o == 8'hFF && gpo_level_reg == 8'hFF))
        else $error("Output pins not high after reset.");

    AST_GPO_FOLLOW : assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!reset_i && !pin5_alt_i) |=> (out_pin_o[5] == $past(gpo_level_reg[5])) && out_pin_oe_o[5])
        else $error("Pin five does not show general output level.");

endmodule : output_port_function_mux
`default_nettype wire

// ### hdl/output_port_function_mux_cfg.svh
// Constants for the output pin multiplexer: reset values and pin positions.
`ifndef OUTPUT_PORT_FUNCTION_MUX_CFG_SVH
`define OUTPUT_PORT_FUNCTION_MUX_CFG_SVH

`define OPM_GPO_RESET      8'hFF
`define OPM_PIN_OE_RESET   8'hFF
`define OPM_DATA_RESET     8'h00
`define OPM_PIN_ONE        1
`define OPM_PIN_THREE      3
`define OPM_PIN_FIVE       5
`define OPM_PIN_SIX        6
`define OPM_PIN_SEVEN      7

`endif

// ### hdl/output_port_function_mux_pkg.sv
// Types shared by the output pin multiplexer files.
`default_nettype none
package output_port_function_mux_pkg;

    typedef enum logic [1:0] {
        PIN3_GPO,
        PIN3_TX_CLOCK,
        PIN3_RX_CLOCK,
        PIN3_CT_READY
    } pin3_func_t;

    typedef logic [7:0] byte_t;

endpackage : output_port_function_mux_pkg
`default_nettype wire

// ### verif/host_bus_model.sv
// Host processor model driving chip select, strobes and write data of the parallel bus.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic       ref_clk_i,
    output logic [7:0]      data_o,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o
);
    initial begin
        data_o = 8'h00;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    task automatic write_byte(input logic [7:0] d, input logic sel_n);
        @(posedge ref_clk_i);
        cs_n_o <= sel_n;
        wr_n_o <= 1'b0;
        data_o <= d;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        // A released bus shows the inverse, so a stale byte is never taken as valid.
        data_o <= ~d;
    endtask : write_byte
    task automatic read_set(input logic low);
        @(posedge ref_clk_i);
        cs_n_o <= ~low;
        rd_n_o <= ~low;
    endtask : read_set
endmodule : host_bus_model
`default_nettype wire

// ### verif/test_output_port_function_mux.sv
// Self-checking bench for the output pin multiplexer, bus drive and interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module test_output_port_function_mux;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cs_n_i, rd_n_i, wr_n_i, z_mode_i, interrupt_acknowledge_i, data_oe_o, wr_pulse_o, seen;
    logic        pin1_alt_i, pin5_alt_i, pin6_alt_i, pin7_alt_i, interrupt_request_n_o, interrupt_request_n_oe_o;
    logic        chan_b_request_to_send_n_i, chan_b_tx_clock_x1_i, chan_b_rx_clock_x1_i, ct_ready_n_i;
    logic        chan_b_rx_ready_or_full_n_i, chan_b_tx_ready_n_i, chan_a_tx_ready_n_i;
    logic [7:0]  data_in_i, data_out_o, read_data_i, vector_i, wr_data_o, gpo_drive_low_i, gpo_drive_high_i;
    logic [7:0]  gpo_level_o, out_pin_o, out_pin_oe_o, int_source_i, int_mask_i, gpo_exp;
    logic [31:0] lfsr = 32'h562E;
    int          error_cnt = 0;
    int          n_checks = 0;
    output_port_function_mux_pkg::pin3_func_t pin3_func_i;

    always #2 ref_clk_i = ~ref_clk_i;

    output_port_function_mux output_port_function_mux_inst (
        .ref_clk_i, .reset_i, .cs_n_i, .rd_n_i, .wr_n_i, .z_mode_i, .interrupt_acknowledge_i, .data_in_i,
        .data_out_o, .data_oe_o, .read_data_i, .vector_i, .wr_pulse_o, .wr_data_o, .gpo_drive_low_i,
        .gpo_drive_high_i, .gpo_level_o, .pin1_alt_i, .pin3_func_i, .pin5_alt_i, .pin6_alt_i, .pin7_alt_i,
        .chan_b_request_to_send_n_i, .chan_b_tx_clock_x1_i, .chan_b_rx_clock_x1_i, .ct_ready_n_i,
        .chan_b_rx_ready_or_full_n_i, .chan_b_tx_ready_n_i, .chan_a_tx_ready_n_i, .out_pin_o, .out_pin_oe_o,
        .int_source_i, .int_mask_i, .interrupt_request_n_o, .interrupt_request_n_oe_o
    );
    host_bus_model host_bus_model_inst (
        .ref_clk_i, .data_o(data_in_i), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i)
    );

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    // Open-drain alternates drive level 0 and enable only while their source is asserted.
    function automatic logic [15:0] exp_pins();
        logic [7:0] lvl;
        logic [7:0] oe;
        lvl = gpo_exp;
        oe = 8'hFF;
        if (pin1_alt_i) lvl[1] = chan_b_request_to_send_n_i;
        case (pin3_func_i)
            output_port_function_mux_pkg::PIN3_TX_CLOCK: lvl[3] = chan_b_tx_clock_x1_i;
            output_port_function_mux_pkg::PIN3_RX_CLOCK: lvl[3] = chan_b_rx_clock_x1_i;
            output_port_function_mux_pkg::PIN3_CT_READY: {lvl[3], oe[3]} = {1'b0, ~ct_ready_n_i};
            default: ;
        endcase
        if (pin5_alt_i) {lvl[5], oe[5]} = {1'b0, ~chan_b_rx_ready_or_full_n_i};
        if (pin6_alt_i) {lvl[6], oe[6]} = {1'b0, ~chan_a_tx_ready_n_i};
        if (pin7_alt_i) {lvl[7], oe[7]} = {1'b0, ~chan_b_tx_ready_n_i};
        return {oe, lvl};
    endfunction : exp_pins

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_reset;
        #1;
        check_byte("out_pin_rst", 8'hFF, out_pin_o);
        check_byte("gpo_rst", 8'hFF, gpo_level_o);
        check_byte("out_pin_oe_rst", 8'hFF, out_pin_oe_o);
        check_bit("wr_pulse_rst", 1'b0, wr_pulse_o);
        check_bit("irq_oe_rst", 1'b0, interrupt_request_n_oe_o);
        gpo_exp = 8'hFF;
    endtask : check_reset

    task automatic write_test(input logic [7:0] d);
        int n;
        host_bus_model_inst.write_byte(d, 1'b0);
        n = 0;
        #1;
        while (wr_pulse_o !== 1'b1 && n < 6) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (wr_pulse_o !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED wr_pulse expected 1 seen timeout");
            test_done();
        end
        check_byte("wr_data", d, wr_data_o);
        @(posedge ref_clk_i);
        #1;
        check_bit("wr_pulse_len", 1'b0, wr_pulse_o);
    endtask : write_test

    // Drive drive pulses last one cycle while selects and sources stay held until the compare.
    task automatic random_step(input int f3);
        logic [31:0] a;
        logic [31:0] b;
        logic [15:0] p;
        a = lfsr_step(lfsr);
        b = lfsr_step(a);
        lfsr = b;
        @(posedge ref_clk_i);
        {gpo_drive_high_i, gpo_drive_low_i, int_source_i, int_mask_i} <= a;
        {pin1_alt_i, pin5_alt_i, pin6_alt_i, pin7_alt_i, chan_b_request_to_send_n_i} <= b[4:0];
        {chan_b_tx_clock_x1_i, chan_b_rx_clock_x1_i, ct_ready_n_i} <= b[7:5];
        {chan_b_rx_ready_or_full_n_i, chan_b_tx_ready_n_i, chan_a_tx_ready_n_i} <= b[10:8];
        pin3_func_i <= output_port_function_mux_pkg::pin3_func_t'((f3 < 0) ? b[12:11] : f3[1:0]);
        gpo_exp = (gpo_exp | a[31:24]) & ~a[23:16];
        @(posedge ref_clk_i);
        {gpo_drive_high_i, gpo_drive_low_i} <= 16'h0000;
        @(posedge ref_clk_i);
        #1;
        p = exp_pins();
        check_byte("gpo_level", gpo_exp, gpo_level_o);
        check_byte("out_pin", p[7:0], out_pin_o);
        check_byte("out_pin_oe", p[15:8], out_pin_oe_o);
        check_bit("irq_oe", |(a[15:8] & a[7:0]), interrupt_request_n_oe_o);
        check_bit("irq_n", ~|(a[15:8] & a[7:0]), interrupt_request_n_o);
    endtask : random_step

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        {z_mode_i, interrupt_acknowledge_i, pin1_alt_i, pin5_alt_i, pin6_alt_i, pin7_alt_i} = 6'h00;
        {chan_b_request_to_send_n_i, chan_b_tx_clock_x1_i, chan_b_rx_clock_x1_i, ct_ready_n_i} = 4'hF;
        {chan_b_rx_ready_or_full_n_i, chan_b_tx_ready_n_i, chan_a_tx_ready_n_i} = 3'h7;
        {read_data_i, vector_i, gpo_drive_low_i, gpo_drive_high_i, int_source_i, int_mask_i} = 48'h0;
        pin3_func_i = output_port_function_mux_pkg::PIN3_GPO;
        repeat (4) @(posedge ref_clk_i);
        check_reset();
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        $display("reset test done");
        write_test(8'h01);
        write_test(8'h80);
        write_test(lfsr[15:8]);
        host_bus_model_inst.write_byte(8'h5A, 1'b1);
        seen = 1'b0;
        repeat (4) begin
            @(posedge ref_clk_i);
            #1;
            seen |= wr_pulse_o;
        end
        check_bit("wr_refused", 1'b0, seen);
        $display("write test done");
        @(posedge ref_clk_i);
        read_data_i <= lfsr[7:0];
        host_bus_model_inst.read_set(1'b1);
        #1;
        check_bit("read_oe", 1'b1, data_oe_o);
        @(posedge ref_clk_i);
        #1;
        check_byte("read_data", lfsr[7:0], data_out_o);
        host_bus_model_inst.read_set(1'b0);
        #1;
        check_bit("idle_oe", 1'b0, data_oe_o);
        @(posedge ref_clk_i);
        {z_mode_i, interrupt_acknowledge_i} <= 2'b11;
        vector_i <= ~lfsr[7:0];
        #1;
        check_bit("ack_oe", 1'b1, data_oe_o);
        @(posedge ref_clk_i);
        #1;
        check_byte("vector", ~lfsr[7:0], data_out_o);
        @(posedge ref_clk_i);
        z_mode_i <= 1'b0;
        #1;
        check_bit("ack_no_z", 1'b0, data_oe_o);
        @(posedge ref_clk_i);
        interrupt_acknowledge_i <= 1'b0;
        $display("bus test done");
        for (int i = 0; i < 48; i++) random_step((i < 4) ? i : -1);
        $display("pin test done");
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        @(posedge ref_clk_i);
        check_reset();
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        random_step(3);
        $display("second reset test done");
        test_done();
    end
endmodule : test_output_port_function_mux
`default_nettype wire
